// ### design/bus_agent_regs.svh
// constants for the processor-side bus agent: response codes, inversion limit, timing
// assumes the bus clock period is a whole multiple of the core clock period
`ifndef BUS_AGENT_REGS_SVH
`define BUS_AGENT_REGS_SVH

// ==========================================
// response codes (logical, asserted = 1)
`define RESP_IDLE        3'h0
`define RESP_RETRY       3'h1
`define RESP_DEFERRED    3'h2
`define RESP_NO_DATA     3'h5
`define RESP_IMPLICIT_WB 3'h6
`define RESP_NORMAL_DATA 3'h7

// ==========================================
// data inversion
`define DBI_GROUP_W   16
`define DBI_GROUPS    4
`define DBI_LOW_LIMIT 8

// ==========================================
// widths
`define ADDR_W   33
`define DATA_W   64
`define LINE_W   256
`define CMD_W    5
`define SYNC_W   122

// ==========================================
// timing
`define CLK_PERIOD_NS     20
`define BUS_CLK_PERIOD_NS 160
`define BUS_PHASES        (`BUS_CLK_PERIOD_NS / `CLK_PERIOD_NS)
`define LAST_PHASE        3'(`BUS_PHASES - 1)

`endif

// ### design/bus_agent_pkg.sv
// types shared by the processor-side bus agent
// assumes nothing of its surroundings
package bus_agent_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAIT_TRDY,
    ST_WR_DATA,
    ST_WAIT_RESP,
    ST_RD_DATA
  } agent_state_t;
endpackage

// ### design/dbi_lane.sv
// one 16-bit data group: inversion encode for writes, strobe capture and restore for reads
// assumes inputs are already synchronised to clk; pins are active-low electrical levels
`timescale 1ns/100ps
`include "bus_agent_regs.svh"
module dbi_lane #(
  parameter int WIDTH = `DBI_GROUP_W
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // capture
  input  wire logic               clear,
  input  wire logic               captFall,
  input  wire logic [WIDTH-1:0]   pinIn_n,
  input  wire logic               flagIn_n,
  // encode
  input  wire logic [WIDTH-1:0]   wrWord,
  output logic      [WIDTH-1:0]   encOut_n,
  output logic                    encFlag_n,
  // read result
  output logic      [4*WIDTH-1:0] rdWords,
  output logic                    rdDone
);
  logic             invert;
  logic [2:0]       cnt_reg;
  logic [WIDTH-1:0] restored;

  // ==========================================
  // encode
  always_comb begin
    invert    = ($countones(wrWord) > `DBI_LOW_LIMIT);
    encOut_n  = invert ? wrWord : ~wrWord;
    encFlag_n = ~invert;
  end

  // ==========================================
  // capture
  assign restored = ~pinIn_n ^ {WIDTH{~flagIn_n}};
  assign rdDone   = cnt_reg[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 3'h0;
      rdWords <= '0;
    end else if (clear) begin
      cnt_reg <= 3'h0;
    end else if (captFall && !cnt_reg[2]) begin
      rdWords[cnt_reg[1:0]*WIDTH +: WIDTH] <= restored;
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
endmodule // dbi_lane

// ### design/bus_agent_host.sv
// processor-side agent on the shared front-side bus, facing the hub device
// assumes the bench resolves each pin from out and oe_n; bus clock sampled, 8 clk per period
// Functional notes
// - a request starts with the address strobe; the device strobes its own snoops.
// - block-next-request stops the owner from starting further requests.
// - priority request stops new requests unless a locked sequence runs.
// - invert a 16-bit group and flag it when over eight bits low.
// - the data owner holds data-busy across its data phase.
// - data-ready is asserted in each cycle carrying valid data.
// - address lines are driven by requester, by device during snoops, at 2x.
// - two address strobes clock address and command lines at 2x.
// - data moves at 4x; receivers restore each group from its flag.
// - hit-modified claims the line; hit plus hit-modified stretches the snoop; the agent drives both pins for one bus clock only, with no stretch.
// - page-close hint in both request halves asks for auto-precharge.
// - command lines carry snoop-level type first half, full type second half.
`timescale 1ns/100ps
`include "bus_agent_regs.svh"
module bus_agent_host (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // user request
  input  wire logic                   reqValid,
  input  wire logic                   reqWrite,
  input  wire logic                   reqLock,
  input  wire logic                   reqPageClose,
  input  wire logic [`ADDR_W-1:0]     reqAddr,
  input  wire logic [`CMD_W-1:0]      reqCmdFirst,
  input  wire logic [`CMD_W-1:0]      reqCmdSecond,
  input  wire logic [`LINE_W-1:0]     reqWrData,
  output logic                        reqReady,
  // user answer
  output logic                        respValid,
  output logic [2:0]                  respCode,
  output logic                        respDeferred,
  output logic                        rdValid,
  output logic [`LINE_W-1:0]          rdData,
  // user snoop
  input  wire logic                   snoopHitIn,
  input  wire logic                   snoopHitModIn,
  output logic                        snoopValid,
  output logic [`ADDR_W-1:0]          snoopAddr,
  // reset status
  output logic                        resetActive,
  output logic                        strapBusReqLow,
  // pins from the device
  input  wire logic                   busClk,
  input  wire logic                   processorResetOut_n,
  input  wire logic                   symmetricBusRequestZero_n,
  input  wire logic                   blockNextRequest_n,
  input  wire logic                   priorityBusRequest_n,
  input  wire logic                   earlyDataValid_n,
  input  wire logic                   targetReady_n,
  input  wire logic                   deferIndication_n,
  input  wire logic [2:0]             responseCode_n,
  // request pins
  input  wire logic                   requestAddressStrobeIn_n,
  output logic                        requestAddressStrobeOut_n,
  output logic                        requestAddressStrobeOe_n,
  output logic [`CMD_W-1:0]           requestCommandLinesOut_n,
  output logic                        requestCommandLinesOe_n,
  input  wire logic [`ADDR_W-1:0]     hostAddressLinesIn_n,
  output logic [`ADDR_W-1:0]          hostAddressLinesOut_n,
  output logic                        hostAddressLinesOe_n,
  output logic [1:0]                  addressSourceStrobesOut_n,
  output logic                        addressSourceStrobesOe_n,
  output logic                        pageCloseHint_n,
  output logic                        atomicLockOut_n,
  output logic                        atomicLockOe_n,
  // data pins
  output logic                        dataBusBusyOut_n,
  output logic                        dataBusBusyOe_n,
  input  wire logic                   dataValidStrobeIn_n,
  output logic                        dataValidStrobeOut_n,
  output logic                        dataValidStrobeOe_n,
  input  wire logic [`DATA_W-1:0]     hostDataLinesIn_n,
  output logic [`DATA_W-1:0]          hostDataLinesOut_n,
  output logic                        hostDataLinesOe_n,
  input  wire logic [`DBI_GROUPS-1:0] dataInversionFlagsIn_n,
  output logic [`DBI_GROUPS-1:0]      dataInversionFlagsOut_n,
  input  wire logic [`DBI_GROUPS-1:0] dataStrobePosIn_n,
  input  wire logic [`DBI_GROUPS-1:0] dataStrobeNegIn_n,
  output logic [`DBI_GROUPS-1:0]      dataStrobePosOut_n,
  output logic [`DBI_GROUPS-1:0]      dataStrobeNegOut_n,
  // snoop pins
  output logic                        snoopHitCleanOut_n,
  output logic                        snoopHitCleanOe_n,
  output logic                        snoopHitModifiedOut_n,
  output logic                        snoopHitModifiedOe_n
);
  bus_agent_pkg::agent_state_t state_reg;
  logic [`SYNC_W-1:0]     syncA_reg, syncB_reg;
  logic                   sBusClk, sRst, sBreq0, sAds, sBnr, sBpri, sDvs, sEdrdy, sTrdy, sDefer;
  logic [2:0]             sResp;
  logic [`ADDR_W-1:0]     sAddr_n;
  logic [`DATA_W-1:0]     sData_n;
  logic [`DBI_GROUPS-1:0] sInv_n, sStbP_n, sStbN_n, prevP_reg, prevN_reg, laneDone;
  logic [`DBI_GROUPS-1:0] encFlag_n;
  logic [`DATA_W-1:0]     encData_n, wrChunk;
  logic [`LINE_W-1:0]     laneWords;
  logic                   prevBusClk_reg, prevRst_reg, busRise, lockActive_reg, snoopDrive_reg;
  logic [2:0]             phase_reg;
  logic                   curWrite_reg, curPageClose_reg;
  logic [`ADDR_W-1:0]     curAddr_reg;
  logic [`CMD_W-1:0]      curCmdA_reg, curCmdB_reg;
  logic [`LINE_W-1:0]     curData_reg;
  logic                   driveReq, driveData, laneClear, mayStart;

  // ==========================================
  // pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // processor held in reset, bus clock low: no false edge after reset
      syncA_reg <= {2'h0, {(`SYNC_W-2){1'b1}}};
      syncB_reg <= {2'h0, {(`SYNC_W-2){1'b1}}};
    end else begin
      syncA_reg <= {busClk, processorResetOut_n, symmetricBusRequestZero_n,
                    requestAddressStrobeIn_n, blockNextRequest_n, priorityBusRequest_n,
                    dataValidStrobeIn_n, earlyDataValid_n, targetReady_n, deferIndication_n,
                    responseCode_n, hostAddressLinesIn_n, hostDataLinesIn_n,
                    dataInversionFlagsIn_n, dataStrobePosIn_n, dataStrobeNegIn_n};
      syncB_reg <= syncA_reg;
    end
  end

  assign sBusClk = syncB_reg[121];
  assign {sRst, sBreq0, sAds, sBnr, sBpri, sDvs, sEdrdy, sTrdy, sDefer} = ~syncB_reg[120:112];
  assign sResp   = ~syncB_reg[111:109];
  assign sAddr_n = syncB_reg[108:76];
  assign sData_n = syncB_reg[75:12];
  assign sInv_n  = syncB_reg[11:8];
  assign sStbP_n = syncB_reg[7:4];
  assign sStbN_n = syncB_reg[3:0];
  assign busRise = sBusClk && !prevBusClk_reg;

  // ==========================================
  // bus clock phase and reset strap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevBusClk_reg <= 1'b0;
      phase_reg      <= 3'h0;
      prevRst_reg    <= 1'b1;
      resetActive    <= 1'b1;
      strapBusReqLow <= 1'b0;
      prevP_reg      <= '1;
      prevN_reg      <= '1;
    end else begin
      prevBusClk_reg <= sBusClk;
      prevP_reg      <= sStbP_n;
      prevN_reg      <= sStbN_n;
      if (busRise)
        phase_reg <= 3'h0;
      else if (phase_reg != `LAST_PHASE)
        phase_reg <= phase_reg + 3'h1;
      prevRst_reg <= sRst;
      resetActive <= sRst;
      if (prevRst_reg && !sRst)
        strapBusReqLow <= sBreq0;
    end
  end

  // ==========================================
  // transaction state machine, stepped on bus clock edges
  assign mayStart  = reqValid && !sBnr && (!sBpri || lockActive_reg);
  assign laneClear = busRise && (state_reg == bus_agent_pkg::ST_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg        <= bus_agent_pkg::ST_IDLE;
      reqReady         <= 1'b0;
      respValid        <= 1'b0;
      respCode         <= `RESP_IDLE;
      respDeferred     <= 1'b0;
      rdValid          <= 1'b0;
      rdData           <= '0;
      curWrite_reg     <= 1'b0;
      curPageClose_reg <= 1'b0;
      curAddr_reg      <= '0;
      curCmdA_reg      <= '0;
      curCmdB_reg      <= '0;
      curData_reg      <= '0;
      lockActive_reg   <= 1'b0;
    end else begin
      reqReady  <= 1'b0;
      respValid <= 1'b0;
      rdValid   <= 1'b0;
      if (state_reg == bus_agent_pkg::ST_IDLE && !reqLock)
        lockActive_reg <= 1'b0;
      if (busRise) begin
        unique case (state_reg)
          bus_agent_pkg::ST_IDLE: begin
            if (!resetActive && mayStart) begin
              state_reg        <= bus_agent_pkg::ST_REQ;
              reqReady         <= 1'b1;
              curWrite_reg     <= reqWrite;
              curPageClose_reg <= reqPageClose;
              curAddr_reg      <= reqAddr;
              curCmdA_reg      <= reqCmdFirst;
              curCmdB_reg      <= reqCmdSecond;
              curData_reg      <= reqWrData;
              respDeferred     <= 1'b0;
              if (reqLock)
                lockActive_reg <= 1'b1;
            end
          end
          bus_agent_pkg::ST_REQ: begin
            state_reg <= curWrite_reg ? bus_agent_pkg::ST_WAIT_TRDY
                                      : bus_agent_pkg::ST_WAIT_RESP;
          end
          bus_agent_pkg::ST_WAIT_TRDY: begin
            if (sDefer)
              respDeferred <= 1'b1;
            if (sResp != `RESP_IDLE) begin
              state_reg <= bus_agent_pkg::ST_IDLE;
              respCode  <= sResp;
              respValid <= 1'b1;
            end else if (sTrdy) begin
              state_reg <= bus_agent_pkg::ST_WR_DATA;
            end
          end
          bus_agent_pkg::ST_WR_DATA: begin
            state_reg <= bus_agent_pkg::ST_WAIT_RESP;
          end
          bus_agent_pkg::ST_WAIT_RESP: begin
            if (sDefer)
              respDeferred <= 1'b1;
            if (sResp != `RESP_IDLE) begin
              respCode <= sResp;
              if (sResp == `RESP_NORMAL_DATA && !curWrite_reg) begin
                state_reg <= bus_agent_pkg::ST_RD_DATA;
              end else begin
                state_reg <= bus_agent_pkg::ST_IDLE;
                respValid <= 1'b1;
              end
            end
          end
          bus_agent_pkg::ST_RD_DATA: begin
            if (&laneDone) begin
              state_reg <= bus_agent_pkg::ST_IDLE;
              respValid <= 1'b1;
              rdValid   <= 1'b1;
              rdData    <= laneWords;
            end
          end
        endcase
      end
    end
  end

  // ==========================================
  // data groups
  assign wrChunk = curData_reg[phase_reg[2:1]*`DATA_W +: `DATA_W];

  genvar g;
  generate
    for (g = 0; g < `DBI_GROUPS; g++) begin : gLane
      logic [4*`DBI_GROUP_W-1:0] rawWords;
      dbi_lane #(.WIDTH(`DBI_GROUP_W)) uLane (
        .clk      (clk),
        .rst_n    (rst_n),
        .clear    (laneClear),
        .captFall ((prevP_reg[g] && !sStbP_n[g]) || (prevN_reg[g] && !sStbN_n[g])),
        .pinIn_n  (sData_n[g*`DBI_GROUP_W +: `DBI_GROUP_W]),
        .flagIn_n (sInv_n[g]),
        .wrWord   (wrChunk[g*`DBI_GROUP_W +: `DBI_GROUP_W]),
        .encOut_n (encData_n[g*`DBI_GROUP_W +: `DBI_GROUP_W]),
        .encFlag_n(encFlag_n[g]),
        .rdWords  (rawWords),
        .rdDone   (laneDone[g])
      );
      for (genvar q = 0; q < 4; q++) begin : gWord
        assign laneWords[q*`DATA_W + g*`DBI_GROUP_W +: `DBI_GROUP_W] =
          rawWords[q*`DBI_GROUP_W +: `DBI_GROUP_W];
      end
    end
  endgenerate

  // ==========================================
  // snoop detection; no own strobe can be mistaken, ads is sampled outside REQ only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snoopValid     <= 1'b0;
      snoopAddr      <= '0;
      snoopDrive_reg <= 1'b0;
    end else begin
      snoopValid <= 1'b0;
      if (busRise) begin
        snoopDrive_reg <= 1'b0;
        if (sAds && state_reg != bus_agent_pkg::ST_REQ) begin
          snoopValid     <= 1'b1;
          snoopAddr      <= ~sAddr_n;
          snoopDrive_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // pin drivers, all registered so pins move together one clk after the phase
  assign driveReq  = (state_reg == bus_agent_pkg::ST_REQ);
  assign driveData = (state_reg == bus_agent_pkg::ST_WR_DATA);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      requestAddressStrobeOut_n <= 1'b1;
      requestAddressStrobeOe_n  <= 1'b1;
      requestCommandLinesOut_n  <= '1;
      requestCommandLinesOe_n   <= 1'b1;
      hostAddressLinesOut_n     <= '1;
      hostAddressLinesOe_n      <= 1'b1;
      addressSourceStrobesOut_n <= 2'h3;
      addressSourceStrobesOe_n  <= 1'b1;
      pageCloseHint_n           <= 1'b1;
      atomicLockOut_n           <= 1'b1;
      atomicLockOe_n            <= 1'b1;
    end else begin
      requestAddressStrobeOut_n <= ~driveReq;
      requestAddressStrobeOe_n  <= ~driveReq;
      requestCommandLinesOut_n  <= phase_reg[2] ? ~curCmdB_reg : ~curCmdA_reg;
      requestCommandLinesOe_n   <= ~driveReq;
      hostAddressLinesOut_n     <= ~curAddr_reg;
      hostAddressLinesOe_n      <= ~driveReq;
      addressSourceStrobesOut_n <= {2{~(driveReq && phase_reg[1])}};
      addressSourceStrobesOe_n  <= ~driveReq;
      pageCloseHint_n           <= ~(driveReq && curPageClose_reg);
      atomicLockOut_n           <= ~lockActive_reg;
      atomicLockOe_n            <= ~lockActive_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataBusBusyOut_n        <= 1'b1;
      dataBusBusyOe_n         <= 1'b1;
      dataValidStrobeOut_n    <= 1'b1;
      dataValidStrobeOe_n     <= 1'b1;
      hostDataLinesOut_n      <= '1;
      hostDataLinesOe_n       <= 1'b1;
      dataInversionFlagsOut_n <= '1;
      dataStrobePosOut_n      <= '1;
      dataStrobeNegOut_n      <= '1;
      snoopHitCleanOut_n      <= 1'b1;
      snoopHitCleanOe_n       <= 1'b1;
      snoopHitModifiedOut_n   <= 1'b1;
      snoopHitModifiedOe_n    <= 1'b1;
    end else begin
      dataBusBusyOut_n        <= ~driveData;
      dataBusBusyOe_n         <= ~driveData;
      dataValidStrobeOut_n    <= ~driveData;
      dataValidStrobeOe_n     <= ~driveData;
      hostDataLinesOut_n      <= encData_n;
      hostDataLinesOe_n       <= ~driveData;
      dataInversionFlagsOut_n <= encFlag_n;
      dataStrobePosOut_n      <= {`DBI_GROUPS{~(driveData && phase_reg[1:0] == 2'h1)}};
      dataStrobeNegOut_n      <= {`DBI_GROUPS{~(driveData && phase_reg[1:0] == 2'h3)}};
      snoopHitCleanOut_n      <= ~(snoopDrive_reg && snoopHitIn);
      snoopHitCleanOe_n       <= ~snoopDrive_reg;
      snoopHitModifiedOut_n   <= ~(snoopDrive_reg && snoopHitModIn);
      snoopHitModifiedOe_n    <= ~snoopDrive_reg;
    end
  end

  // ==========================================
  // checks
  block_stops_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    busRise && state_reg == bus_agent_pkg::ST_IDLE && sBnr |=> state_reg == bus_agent_pkg::ST_IDLE)
    else $error("request started while blocked");
  priority_stops_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    busRise && state_reg == bus_agent_pkg::ST_IDLE && sBpri && !lockActive_reg
    |=> state_reg == bus_agent_pkg::ST_IDLE)
    else $error("request started under priority request");
  strobe_frames_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(requestAddressStrobeOut_n) |-> !hostAddressLinesOe_n && !requestCommandLinesOe_n)
    else $error("address strobe without address drive");
  cmd_two_halves_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(requestAddressStrobeOut_n) |-> requestCommandLinesOut_n == ~curCmdA_reg
    ##4 requestCommandLinesOut_n == ~curCmdB_reg)
    else $error("command halves out of order");
  page_close_both_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(requestAddressStrobeOut_n) && curPageClose_reg |-> !pageCloseHint_n [*8])
    else $error("page close hint not held both halves");
  inversion_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    !hostDataLinesOe_n |-> $countones(~hostDataLinesOut_n[15:0]) <= `DBI_LOW_LIMIT)
    else $error("data group has too many low bits");
  busy_covers_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dataValidStrobeOut_n |-> !dataBusBusyOut_n)
    else $error("data ready without data busy");
  ready_with_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    !hostDataLinesOe_n |-> !dataValidStrobeOut_n && !dataValidStrobeOe_n)
    else $error("data driven without data ready");
  strobe_data_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dataStrobePosOut_n[0]) || $fell(dataStrobeNegOut_n[0])
    |-> !hostDataLinesOe_n && $stable(hostDataLinesOut_n))
    else $error("data moved at strobe edge");
endmodule // bus_agent_host

// ### test/hub_device_model.sv
// device side of the bus: reset strapping, target answers, read data, own snoops
// assumes the bench resolves every open-drain pin as a wired-AND with pull-ups
`timescale 1ns/100ps
module hub_device_model #(
  parameter int RST_HOLD  = 12,
  parameter int BREQ_HOLD = 5
) (
  // bench side
  input  wire logic         busClk,
  input  wire logic         sysRst_n,
  input  wire logic         ads_n,
  input  wire logic [2:0]   code,
  input  wire logic         trdyOn,
  input  wire logic         snoopGo,
  input  wire logic [32:0]  snoopA,
  input  wire logic [255:0] line,
  input  wire logic         lock_n,
  // device pins
  output logic              cpuRst_n = 1'h0,
  output logic              breq0_n  = 1'h0,
  output logic              trdy_n   = 1'h1,
  output logic              edv_n    = 1'h1,
  output logic              defer_n  = 1'h1,
  output logic [2:0]        rs_n     = '1,
  output logic              mAds_n   = 1'h1,
  output logic [32:0]       mAddr_n  = '1,
  output logic [63:0]       mData_n  = '1,
  output logic [3:0]        mDbi_n   = '1,
  output logic [3:0]        stbP_n   = '1,
  output logic [3:0]        stbN_n   = '1
);
  // ==========================================
  // reset and strapping; scaled hold stands in for the long delay
  logic [15:0] v;
  logic        inv;
  initial begin
    wait (sysRst_n);
    repeat (RST_HOLD) @(posedge busClk);
    #1 cpuRst_n = 1'h1;
    repeat (BREQ_HOLD) @(posedge busClk);
    #1 breq0_n = 1'h1;
  end
  initial forever begin
    @(posedge busClk);
    if (snoopGo && lock_n) begin
      #1 mAds_n = 1'h0;
      mAddr_n = ~snoopA;
      @(posedge busClk);
      #1 mAds_n = 1'h1;
      mAddr_n = '1;
    end else if (!ads_n && cpuRst_n) begin
      @(posedge busClk);
      if (trdyOn) begin
        #1 trdy_n = 1'h0;
        @(posedge busClk);
        #1 trdy_n = 1'h1;
        repeat (2) @(posedge busClk);
      end
      #1 rs_n = ~code;
      defer_n = !(code inside {3'h1, 3'h2});
      edv_n = !(code == 3'h7 && !trdyOn);
      @(posedge busClk);
      #1 rs_n = '1;
      defer_n = 1'h1;
      edv_n = 1'h1;
      if (code == 3'h7 && !trdyOn) for (int q = 0; q < 4; q++) begin
        for (int g = 0; g < 4; g++) begin
          v = line[64*q+16*g +: 16];
          inv = $countones(v) > 8;
          mData_n[16*g +: 16] = inv ? v : ~v;
          mDbi_n[g] = !inv;
        end
        #40 if (q[0]) stbN_n = '0; else stbP_n = '0;
        #40 stbP_n = '1;
        stbN_n = '1;
      end
      mData_n = '1;
      mDbi_n = '1;
    end
  end
endmodule // hub_device_model

// ### test/tb_host_processor_bus_agent.sv
// self-checking bench: processor-side agent against the device model
// assumes a free-running bus clock and pull-ups on every shared pin
`timescale 1ns/100ps
module tb_host_processor_bus_agent;
  // ==========================================
  logic clk = 1'h0, rst_n = 1'h0, busClk = 1'h0, reqValid = 1'h0, reqWrite = 1'h0;
  logic bnr_n = 1'h1, bpri_n = 1'h1, hit = 1'h0, hitm = 1'h0, trdyOn = 1'h0, sGo = 1'h0;
  logic pc = 1'h0, lk = 1'h0, reqReady, respValid, respDeferred, rdValid, snoopValid, resetActive;
  logic edv_n, lockO;
  logic strap, adsO, adsOe, aOe, dOe, dvsO, dvsOe, cpuRst_n, breq0_n, trdy_n, defer_n, mAds_n;
  logic [32:0] addr = '0, sA = '0, snoopAddr, aO, mAddr_n;
  logic [4:0] cA = '0, cB = '0;
  logic [255:0] line = '0, rdData, wd;
  logic [2:0] code = '0, respCode, rs_n;
  logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  logic [63:0] dO, mData_n;
  logic [3:0] dbiO, pO, nO, mDbi_n, stbP_n, stbN_n;
  int err_count = 0, n_compared = 0;
  always #10 clk = ~clk;
  initial #7 forever #80 busClk = ~busClk;
  bus_agent_host DUT (.clk, .rst_n, .reqValid, .reqWrite, .reqLock(lk), .reqPageClose(pc),
    .reqAddr(addr), .reqCmdFirst(cA), .reqCmdSecond(cB), .reqWrData(line), .reqReady,
    .respValid, .respCode, .respDeferred, .rdValid, .rdData, .snoopHitIn(hit),
    .snoopHitModIn(hitm), .snoopValid, .snoopAddr, .resetActive, .strapBusReqLow(strap),
    .busClk, .processorResetOut_n(cpuRst_n), .symmetricBusRequestZero_n(breq0_n),
    .blockNextRequest_n(bnr_n), .priorityBusRequest_n(bpri_n), .earlyDataValid_n(edv_n),
    .targetReady_n(trdy_n), .deferIndication_n(defer_n), .responseCode_n(rs_n),
    .requestAddressStrobeIn_n((adsOe | adsO) & mAds_n), .requestAddressStrobeOut_n(adsO),
    .requestAddressStrobeOe_n(adsOe), .requestCommandLinesOut_n(), .requestCommandLinesOe_n(),
    .hostAddressLinesIn_n(({33{aOe}} | aO) & mAddr_n), .hostAddressLinesOut_n(aO),
    .hostAddressLinesOe_n(aOe), .addressSourceStrobesOut_n(), .addressSourceStrobesOe_n(),
    .pageCloseHint_n(), .atomicLockOut_n(lockO), .atomicLockOe_n(), .dataBusBusyOut_n(),
    .dataBusBusyOe_n(), .dataValidStrobeIn_n(dvsOe | dvsO), .dataValidStrobeOut_n(dvsO),
    .dataValidStrobeOe_n(dvsOe), .hostDataLinesIn_n(({64{dOe}} | dO) & mData_n),
    .hostDataLinesOut_n(dO), .hostDataLinesOe_n(dOe),
    .dataInversionFlagsIn_n(({4{dOe}} | dbiO) & mDbi_n), .dataInversionFlagsOut_n(dbiO),
    .dataStrobePosIn_n(({4{dOe}} | pO) & stbP_n), .dataStrobeNegIn_n(({4{dOe}} | nO) & stbN_n),
    .dataStrobePosOut_n(pO), .dataStrobeNegOut_n(nO), .snoopHitCleanOut_n(),
    .snoopHitCleanOe_n(), .snoopHitModifiedOut_n(), .snoopHitModifiedOe_n());
  hub_device_model #(.RST_HOLD(12), .BREQ_HOLD(5)) dev (.busClk, .sysRst_n(rst_n),
    .ads_n((adsOe | adsO) & mAds_n), .code, .trdyOn, .snoopGo(sGo), .snoopA(sA), .line,
    .cpuRst_n, .breq0_n, .trdy_n, .defer_n, .rs_n, .mAds_n, .mAddr_n, .mData_n, .mDbi_n,
    .stbP_n, .stbN_n, .lock_n(lockO), .edv_n);
  // write data restored as the far side would see it
  always @(negedge pO[0] or negedge nO[0])
    for (int g = 0; g < 4; g++) wd = {~dO[16*g +: 16] ^ {16{~dbiO[g]}}, wd[255:16]};
  task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for a one-clock pulse, sampled after the edge settles
  task automatic waitHi(ref logic s, input string what);
    repeat (400) begin
      @(posedge clk);
      #2;
      if (s === 1'h1) return;
    end
    chk(what, 1, 0);
  endtask
  function automatic logic [255:0] rl();
    for (int i = 0; i < 8; i++) rl[32*i +: 32] = $urandom;
  endfunction
  task automatic xfer(input logic w, input logic [2:0] c, input logic [255:0] l,
                      input logic [1:0] blk);
    logic seen;
    seen = 1'h0;
    {code, trdyOn, reqWrite, line, pc} = {c, w, w, l, 1'($urandom)};
    {addr, cA, cB} = {33'($urandom), 5'($urandom), 5'($urandom)};
    {bpri_n, bnr_n} = ~blk;
    reqValid = 1'h1;
    if (blk != 2'h0) begin
      repeat (40) begin
        @(posedge clk);
        #2 seen |= reqReady;
      end
      chk("refused", 0, seen);
      {bpri_n, bnr_n} = 2'h3;
    end
    waitHi(reqReady, "reqReady");
    reqValid = 1'h0;
    waitHi(respValid, "respValid");
    chk("respCode", c, respCode);
    chk("rdValid", c == 3'h7 && !w, rdValid);
    if (c == 3'h7 && !w) chk("rdData", l, rdData);
    chk("respDeferred", c inside {3'h1, 3'h2}, respDeferred);
    if (w) chk("wrData", l, wd);
    chk("lock", lk, !lockO);
  endtask
  initial begin
    void'($urandom(32'hb1d45152));
    repeat (2) @(posedge clk);
    #2 rst_n = 1'h1;
    // corner groups: all inverted, none, exactly eight lows, nine lows
    xfer(1'h0, 3'h7, '1, 2'h0);
    chk("strap", 1, strap);
    chk("resetActive", 0, resetActive);
    xfer(1'h0, 3'h7, '0, 2'h2);
    xfer(1'h0, 3'h7, {16{16'h00ff}}, 2'h1);
    xfer(1'h0, 3'h7, {16{16'h01ff}}, 2'h0);
    foreach (codes[i]) xfer(1'h1, codes[i], rl(), 2'h0);
    repeat (12) begin
      lk = 1'($urandom);
      xfer(1'($urandom), codes[$urandom % 5], rl(), 2'h0);
      {lk, sA, hit, hitm} = {1'h0, 33'($urandom), 2'($urandom)};
      sGo = 1'h1;
      waitHi(snoopValid, "snoopValid");
      sGo = 1'h0;
      chk("snoopAddr", sA, snoopAddr);
    end
    end_sim();
  end
  initial begin
    #500000;
    err_count++;
    end_sim();
  end
endmodule // tb_host_processor_bus_agent
